// ### common/eapo_pkg.sv
// Shared constants for the energy accumulator and pulse output block.
package eapo_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Register indices on the register port.
  localparam logic [3:0] REG_ENERGY = 4'h0;
  localparam logic [3:0] REG_ENERGY_ALIAS = 4'h1;
  localparam logic [3:0] REG_OFFSET = 4'h2;
  localparam logic [3:0] REG_DEN = 4'h3;
  localparam logic [3:0] REG_NUM = 4'h4;
  localparam logic [3:0] REG_GAIN = 4'h5;
  localparam logic [3:0] REG_MODE = 4'h6;
  localparam logic [3:0] REG_IRQ_EN = 4'h7;
  localparam logic [3:0] REG_IRQ_STATUS = 4'h8;
  localparam logic [3:0] REG_WAVEFORM = 4'h9;

  ////////////////////////////////////////////////////////////////////////////////
  // Widths.
  localparam int ADDR_W = 4;
  localparam int WDATA_W = 16;
  localparam int ENERGY_W = 40;
  localparam int FRAC_W = 8;
  localparam int ENERGY_INT_W = 48;
  localparam int FREQ_W = 24;
  localparam int DIV_W = 12;
  localparam int GAIN_W = 12;
  localparam int OFFSET_W = 16;
  localparam int MODE_W = 16;
  localparam int IRQ_W = 4;

  ////////////////////////////////////////////////////////////////////////////////
  // Reset values.
  localparam logic [11:0] DEN_RESET = 12'h03f;
  localparam logic [11:0] NUM_RESET = 12'h000;
  localparam logic [11:0] GAIN_RESET = 12'h000;
  localparam logic [15:0] OFFSET_RESET = 16'h0000;
  localparam logic [15:0] MODE_RESET = 16'h0000;
  localparam logic [3:0] IRQ_EN_RESET = 4'h0;

  ////////////////////////////////////////////////////////////////////////////////
  // Field positions.
  localparam int MODE_WAVE_LO = 13;
  localparam int MODE_RATE_LO = 11;
  localparam logic [1:0] WAVE_SEL_POWER = 2'h0;
  localparam int IRQ_HALF = 0;
  localparam int IRQ_WRAP = 1;
  localparam int IRQ_SAMPLE = 3;

  ////////////////////////////////////////////////////////////////////////////////
  // Timing.
  localparam int CLK_PERIOD_NS = 50;
  localparam int UPDATE_DIV = 4;
  localparam int SAMPLE_BASE_UPDATES = 32;
  localparam int PULSE_WIDTH_NS = 1000;
  localparam int PULSE_CYCLES = (PULSE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage : eapo_pkg

// ### rtl/eapo_strobe_gen.sv
// Update strobe and waveform sample strobe generator.
module eapo_strobe_gen
(
  // Clock and reset.
  input wire logic clock_i,
  input wire logic rst_i,
  // Rate select from the mode register.
  input wire logic [1:0] rate_sel_i,
  // Strobes.
  output logic update_o,
  output logic sample_o
);

  logic [1:0] div_q;
  logic [7:0] samp_q;
  logic [7:0] samp_last;

  ////////////////////////////////////////////////////////////////////////////////
  // One update every four master clocks.
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      div_q <= 2'h0;
    end
    else
    begin
      div_q <= div_q + 2'h1;
    end
  end

  assign update_o = (div_q == 2'(eapo_pkg::UPDATE_DIV - 1));

  // Each rate step halves the sample rate.
  assign samp_last = 8'((eapo_pkg::SAMPLE_BASE_UPDATES << rate_sel_i) - 1);

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      samp_q <= 8'h00;
    end
    else if (update_o)
    begin
      samp_q <= (samp_q >= samp_last) ? 8'h00 : samp_q + 8'h01;
    end
  end

  assign sample_o = update_o && (samp_q >= samp_last);

endmodule : eapo_strobe_gen

// ### rtl/eapo_pulse_div.sv
// Fractional divider that thins conversion pulses into fixed-width output pulses.
module eapo_pulse_div #(
  parameter int DW = 12,
  parameter int PULSE_CYCLES = 20
)
(
  // Clock and reset.
  input wire logic clock_i,
  input wire logic rst_i,
  // Conversion pulses and ratio.
  input wire logic pulse_i,
  input wire logic [DW-1:0] num_i,
  input wire logic [DW-1:0] den_i,
  // Output pulse.
  output logic pulse_o
);

  localparam int CW = $clog2(PULSE_CYCLES + 1);

  typedef enum logic [1:0] {
    EAPO_IDLE = 2'b01,
    EAPO_HIGH = 2'b10
  } eapo_div_state_t;

  eapo_div_state_t state_q;
  logic [DW+1:0] acc_q;
  logic [DW+1:0] sum;
  logic [DW+1:0] den_p1;
  logic fire;
  logic pend_q;
  logic [CW-1:0] cnt_q;

  generate
    if (PULSE_CYCLES < 1 || DW < 1)
    begin : g_bad
      $error("eapo_pulse_div: bad parameters");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Pass num+1 of every den+1 pulses on average. (R20)
  assign sum = acc_q + {2'b00, num_i} + 1'b1;
  assign den_p1 = {2'b00, den_i} + 1'b1;
  assign fire = pulse_i && (sum >= den_p1); // (R16)

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      acc_q <= '0;
    end
    else if (pulse_i)
    begin
      acc_q <= fire ? sum - den_p1 : sum;
    end
  end

  // One pending pulse is held while another is out; a burst beyond that is lost,
  // which only happens when conversion pulses arrive faster than the fixed-width output pulses can be sent.
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      state_q <= EAPO_IDLE;
      cnt_q <= '0;
      pend_q <= 1'b0;
    end
    else
    begin
      case (state_q)
        EAPO_IDLE:
        begin
          if (fire || pend_q)
          begin
            state_q <= EAPO_HIGH;
            cnt_q <= CW'(PULSE_CYCLES - 1);
            pend_q <= fire && pend_q;
          end
        end
        EAPO_HIGH:
        begin
          if (fire)
          begin
            pend_q <= 1'b1;
          end
          if (cnt_q == '0)
          begin
            state_q <= EAPO_IDLE;
          end
          else
          begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        default:
        begin
          state_q <= EAPO_IDLE;
        end
      endcase
    end
  end

  assign pulse_o = (state_q == EAPO_HIGH); // (R20)

endmodule : eapo_pulse_div

// ### rtl/eapo_energy_accumulator_pulse_out.sv
// Energy accumulator with offset and gain correction and a frequency pulse output.
//
// Overview of operation
// (R1) Filtered active power is added continuously into a readable 40-bit signed energy register.
// (R2) One accumulation update happens every four master clock cycles.
// (R3) Accumulation is a signed addition; negative power lowers the energy.
// (R4) Positive overflow wraps to the most negative value and keeps counting up.
// (R5) Negative underflow wraps to the most positive value and keeps counting down.
// (R6) Half-full and wrap events are flagged and drive the low interrupt when enabled.
// (R7) Waveform selection 00 with sample enable puts active power into the waveform register.
// (R8) Waveform samples come at 27.9, 14, 7 or 3.5 thousand per second.
// (R9) Mode bits 12:11 choose among the four sample rates.
// (R10) A new waveform sample pulls the active-low interrupt output low.
// (R11) The gain register scales power before accumulation; 7FFh is the largest scale.
// (R12) A 16-bit signed offset is added to the active power.
// (R13) Offset has eight fractional bits: 256 counts equal one waveform count.
// (R14) Active power is also summed into a separate 24-bit frequency accumulator.
// (R15) A 0-to-1 transition of that accumulator's top bit yields one conversion pulse.
// (R16) Pulse rate is scaled by (numerator+1)/(denominator+1) with 12-bit registers.
// (R17) Software keeps the denominator no smaller than the numerator.
// (R18) After reset the denominator reads 3Fh and the numerator reads 0h.
// (R19) With zero dividers the pulse rate is power times clock rate over 2^25.
// (R20) Division passes num+1 of each den+1 pulses, each output of fixed width.
// (R21) The corrected power feeds both accumulators on the same update strobe.
module eapo_energy_accumulator_pulse_out #(
  parameter int PW = 20,
  parameter int PULSE_CYCLES = eapo_pkg::PULSE_CYCLES
)
(
  // Clock and reset.
  input wire logic clock_i,
  input wire logic rst_i,
  // Filtered active power.
  input wire logic [PW-1:0] power_i,
  // Register port.
  input wire logic [eapo_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [eapo_pkg::WDATA_W-1:0] reg_wdata_i,
  input wire logic reg_rd_i,
  output logic [eapo_pkg::ENERGY_W-1:0] reg_rdata_o,
  // Outputs.
  output logic irq_n_o,
  output logic frequency_pulse_o
);

  localparam int EW = eapo_pkg::ENERGY_INT_W;
  localparam int FW = eapo_pkg::FREQ_W;
  localparam int GW = eapo_pkg::GAIN_W;
  localparam int PRODW = PW + GW;
  localparam int SW = PW + 2;
  localparam int CW = SW + eapo_pkg::FRAC_W + 1;

  generate
    if (PW < 8 || PW > 32)
    begin : g_bad
      $error("eapo: power width out of range");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers.

  // Gain is a signed fraction of full scale added on top of unity.
  function automatic logic signed [SW-1:0] scale_power(
    input logic signed [PW-1:0] p,
    input logic signed [GW-1:0] g
  );
    logic signed [PRODW-1:0] prod;
    prod = PRODW'(p) * PRODW'(g);
    scale_power = SW'(p) + SW'($signed(prod[PRODW-1:GW]));
  endfunction : scale_power

  function automatic logic wrapped(
    input logic a,
    input logic b,
    input logic s
  );
    wrapped = (a == b) && (s != a);
  endfunction : wrapped

  ////////////////////////////////////////////////////////////////////////////////
  // Register state.
  logic [eapo_pkg::OFFSET_W-1:0] power_offset_correction_q;
  logic [eapo_pkg::DIV_W-1:0] pulse_divider_denominator_q;
  logic [eapo_pkg::DIV_W-1:0] pulse_divider_numerator_q;
  logic [GW-1:0] power_gain_setting_q;
  logic [eapo_pkg::MODE_W-1:0] mode_q;
  logic [eapo_pkg::IRQ_W-1:0] irq_en_q;
  logic [eapo_pkg::IRQ_W-1:0] irq_status_q;
  logic [eapo_pkg::IRQ_W-1:0] irq_set;
  logic [PW-1:0] waveform_q;
  logic [EW-1:0] energy_q;
  logic [EW-1:0] energy_d;
  logic [FW-1:0] freq_q;
  logic [FW-1:0] freq_d;
  logic [eapo_pkg::ENERGY_W-1:0] rdata_q;

  logic update;
  logic sample;
  logic signed [SW-1:0] scaled;
  logic signed [CW-1:0] corrected;
  logic half_evt;
  logic wrap_evt;
  logic conv_pulse;
  logic sample_evt;

  ////////////////////////////////////////////////////////////////////////////////
  // Strobes.
  eapo_strobe_gen u_strobe
  (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .rate_sel_i(mode_q[eapo_pkg::MODE_RATE_LO +: 2]), // (R9)
    .update_o(update), // (R2)
    .sample_o(sample) // (R8)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Correction datapath.
  assign scaled = scale_power($signed(power_i), $signed(power_gain_setting_q)); // (R11)

  // The offset is added eight bits below the waveform LSB, so 256 counts make one waveform count. (R13)
  assign corrected = $signed({scaled, 8'h00}) + CW'($signed(power_offset_correction_q)); // (R12)

  ////////////////////////////////////////////////////////////////////////////////
  // Energy accumulator, held with eight fractional bits so small offsets add up.
  assign energy_d = energy_q + EW'(corrected); // (R3)

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      energy_q <= '0;
    end
    else if (update) // (R21)
    begin
      energy_q <= energy_d; // (R1) (R4) (R5)
    end
  end

  // Half-full is the move into the upper or lower quarter of the range.
  assign half_evt = update && (
    (energy_q[EW-1 -: 2] == 2'b00 && energy_d[EW-1 -: 2] == 2'b01) ||
    (energy_q[EW-1 -: 2] == 2'b11 && energy_d[EW-1 -: 2] == 2'b10)); // (R6)
  assign wrap_evt = update && wrapped(energy_q[EW-1], corrected[CW-1], energy_d[EW-1]); // (R6)

  ////////////////////////////////////////////////////////////////////////////////
  // Frequency accumulator; power enters doubled so a top-bit rise comes per 2^23. (R19)
  assign freq_d = freq_q + FW'(corrected >>> (eapo_pkg::FRAC_W - 1));

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      freq_q <= '0;
    end
    else if (update) // (R21)
    begin
      freq_q <= freq_d; // (R14)
    end
  end

  assign conv_pulse = update && !freq_q[FW-1] && freq_d[FW-1]; // (R15)

  eapo_pulse_div #(
    .DW(eapo_pkg::DIV_W),
    .PULSE_CYCLES(PULSE_CYCLES)
  ) u_div
  (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .pulse_i(conv_pulse),
    .num_i(pulse_divider_numerator_q), // (R16)
    .den_i(pulse_divider_denominator_q), // (R17)
    .pulse_o(frequency_pulse_o)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Waveform sample register.
  assign sample_evt = sample && irq_en_q[eapo_pkg::IRQ_SAMPLE] &&
    (mode_q[eapo_pkg::MODE_WAVE_LO +: 2] == eapo_pkg::WAVE_SEL_POWER); // (R7)

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      waveform_q <= '0;
    end
    else if (sample_evt)
    begin
      waveform_q <= PW'(corrected >>> eapo_pkg::FRAC_W); // (R7)
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Event flags: sticky, cleared by reading the status register; a set wins.
  always_comb
  begin
    irq_set = '0;
    irq_set[eapo_pkg::IRQ_HALF] = half_evt;
    irq_set[eapo_pkg::IRQ_WRAP] = wrap_evt;
    irq_set[eapo_pkg::IRQ_SAMPLE] = sample_evt; // (R10)
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      irq_status_q <= '0;
    end
    else if (reg_rd_i && reg_addr_i == eapo_pkg::REG_IRQ_STATUS)
    begin
      irq_status_q <= irq_set;
    end
    else
    begin
      irq_status_q <= irq_status_q | irq_set;
    end
  end

  assign irq_n_o = ~|(irq_status_q & irq_en_q); // (R6) (R10)

  ////////////////////////////////////////////////////////////////////////////////
  // Register writes.
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      power_offset_correction_q <= eapo_pkg::OFFSET_RESET;
      pulse_divider_denominator_q <= eapo_pkg::DEN_RESET; // (R18)
      pulse_divider_numerator_q <= eapo_pkg::NUM_RESET; // (R18)
      power_gain_setting_q <= eapo_pkg::GAIN_RESET;
      mode_q <= eapo_pkg::MODE_RESET;
      irq_en_q <= eapo_pkg::IRQ_EN_RESET;
    end
    else if (reg_wr_i)
    begin
      if (reg_addr_i == eapo_pkg::REG_OFFSET)
      begin
        power_offset_correction_q <= reg_wdata_i;
      end
      else if (reg_addr_i == eapo_pkg::REG_DEN)
      begin
        pulse_divider_denominator_q <= reg_wdata_i[eapo_pkg::DIV_W-1:0];
      end
      else if (reg_addr_i == eapo_pkg::REG_NUM)
      begin
        pulse_divider_numerator_q <= reg_wdata_i[eapo_pkg::DIV_W-1:0];
      end
      else if (reg_addr_i == eapo_pkg::REG_GAIN)
      begin
        power_gain_setting_q <= reg_wdata_i[GW-1:0];
      end
      else if (reg_addr_i == eapo_pkg::REG_MODE)
      begin
        mode_q <= reg_wdata_i;
      end
      else if (reg_addr_i == eapo_pkg::REG_IRQ_EN)
      begin
        irq_en_q <= reg_wdata_i[eapo_pkg::IRQ_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register reads, answered one cycle after the strobe; unmapped reads give zero.
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      rdata_q <= '0;
    end
    else if (reg_rd_i)
    begin
      if (reg_addr_i == eapo_pkg::REG_ENERGY || reg_addr_i == eapo_pkg::REG_ENERGY_ALIAS)
      begin
        rdata_q <= energy_q[EW-1 -: eapo_pkg::ENERGY_W]; // (R1)
      end
      else if (reg_addr_i == eapo_pkg::REG_OFFSET)
      begin
        rdata_q <= 40'(power_offset_correction_q);
      end
      else if (reg_addr_i == eapo_pkg::REG_DEN)
      begin
        rdata_q <= 40'(pulse_divider_denominator_q);
      end
      else if (reg_addr_i == eapo_pkg::REG_NUM)
      begin
        rdata_q <= 40'(pulse_divider_numerator_q);
      end
      else if (reg_addr_i == eapo_pkg::REG_GAIN)
      begin
        rdata_q <= 40'(power_gain_setting_q);
      end
      else if (reg_addr_i == eapo_pkg::REG_MODE)
      begin
        rdata_q <= 40'(mode_q);
      end
      else if (reg_addr_i == eapo_pkg::REG_IRQ_EN)
      begin
        rdata_q <= 40'(irq_en_q);
      end
      else if (reg_addr_i == eapo_pkg::REG_IRQ_STATUS)
      begin
        rdata_q <= 40'(irq_status_q);
      end
      else if (reg_addr_i == eapo_pkg::REG_WAVEFORM)
      begin
        rdata_q <= 40'(waveform_q);
      end
      else
      begin
        rdata_q <= '0;
      end
    end
  end

  assign reg_rdata_o = rdata_q;

endmodule : eapo_energy_accumulator_pulse_out

// ### verification/eapo_energy_accumulator_pulse_out_properties.sv
// Port-level checker for the energy accumulator and pulse output block.
module eapo_energy_accumulator_pulse_out_properties #(
  parameter int PW = 20,
  parameter int PULSE_CYCLES = 20
)
(
  // Clock and reset.
  input wire logic clock_i,
  input wire logic rst_i,
  // Inputs of the block.
  input wire logic [PW-1:0] power_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_rd_i,
  // Outputs of the block.
  input wire logic [39:0] reg_rdata_o,
  input wire logic irq_n_o,
  input wire logic frequency_pulse_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [11:0] den_q;
  logic [11:0] num_q;
  logic [3:0] en_q;
  logic pd_q;
  int hi_q;
  int since_q;
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////////////////////////
  // Shadows of the divider and interrupt enable settings, so read data and the interrupt can be predicted.
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      den_q <= eapo_pkg::DEN_RESET;
      num_q <= eapo_pkg::NUM_RESET;
      en_q <= '0;
    end
    else if (reg_wr_i)
    begin
      if (reg_addr_i == eapo_pkg::REG_DEN) den_q <= reg_wdata_i[11:0];
      if (reg_addr_i == eapo_pkg::REG_NUM) num_q <= reg_wdata_i[11:0];
      if (reg_addr_i == eapo_pkg::REG_IRQ_EN) en_q <= reg_wdata_i[3:0];
    end
  end
  // Pulse length and rise spacing counters; the spacing counter saturates so long idle stays harmless.
  always_ff @(posedge clock_i)
  begin
    pd_q <= rst_i ? 1'b0 : frequency_pulse_o;
    hi_q <= (rst_i || !frequency_pulse_o) ? 0 : hi_q + 1;
    if (rst_i) since_q <= 1000;
    else if (frequency_pulse_o && !pd_q) since_q <= 1;
    else if (since_q < 1000) since_q <= since_q + 1;
  end
  ////////////////////////////////////////////////////////////////////////////////
  a_reset_quiet: assert property (disable iff (1'b0) rst_i |=> irq_n_o && !frequency_pulse_o && reg_rdata_o == 40'h0) else $error("outputs not idle after reset");
  a_rdata_hold: assert property (!reg_rd_i |=> $stable(reg_rdata_o)) else $error("read data moved without a read");
  a_den_value: assert property (reg_rd_i && reg_addr_i == eapo_pkg::REG_DEN |=> reg_rdata_o == {28'h0, $past(den_q)}) else $error("denominator read mismatch");
  a_num_value: assert property (reg_rd_i && reg_addr_i == eapo_pkg::REG_NUM |=> reg_rdata_o == {28'h0, $past(num_q)}) else $error("numerator read mismatch");
  a_unmapped_zero: assert property (reg_rd_i && reg_addr_i > eapo_pkg::REG_WAVEFORM |=> reg_rdata_o == 40'h0) else $error("unmapped read not zero");
  a_irq_masked: assert property (en_q == 4'h0 |-> irq_n_o) else $error("interrupt low with all enables clear");
  a_pulse_width: assert property ($fell(frequency_pulse_o) |-> hi_q == PULSE_CYCLES) else $error("output pulse width wrong");
  a_pulse_spacing: assert property ($rose(frequency_pulse_o) |-> since_q > PULSE_CYCLES) else $error("output pulses too close");
endmodule : eapo_energy_accumulator_pulse_out_properties

bind eapo_energy_accumulator_pulse_out eapo_energy_accumulator_pulse_out_properties #(
  .PW(PW), .PULSE_CYCLES(PULSE_CYCLES)) eapo_energy_accumulator_pulse_out_properties_inst (
  .clock_i(clock_i), .rst_i(rst_i), .power_i(power_i), .reg_addr_i(reg_addr_i),
  .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .irq_n_o(irq_n_o), .frequency_pulse_o(frequency_pulse_o));

// ### verification/eapo_pulse_counter.sv
// Model of the calibration counter that tallies output pulses.
module eapo_pulse_counter
(
  // Clock and reset.
  input wire logic clock_i,
  input wire logic rst_i,
  // Pulse line.
  input wire logic pulse_i,
  // Running tally of rising edges.
  output logic [15:0] count_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic last_q;
  // Counts edges, not high cycles, so the pulse width does not skew the rate.
  always_ff @(posedge clock_i)
  begin
    last_q <= rst_i ? 1'b0 : pulse_i;
    if (rst_i) count_o <= 16'h0000;
    else if (pulse_i && !last_q) count_o <= count_o + 16'h0001;
  end
endmodule : eapo_pulse_counter

// ### verification/eapo_energy_accumulator_pulse_out_bench.sv
// Self-checking testbench for the energy accumulator and pulse output block.
module eapo_energy_accumulator_pulse_out_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PW = 20;
  localparam int PC = 2;
  logic clock_i, rst_i, reg_wr_i, reg_rd_i, irq_n_o, frequency_pulse_o;
  logic [PW-1:0] power_i;
  logic [3:0] reg_addr_i;
  logic [15:0] reg_wdata_i, count;
  logic [39:0] reg_rdata_o;
  int err_count = 0;
  int checked = 0;
  int cyc = 0;
  eapo_energy_accumulator_pulse_out #(.PW(PW), .PULSE_CYCLES(PC))
    eapo_energy_accumulator_pulse_out_inst (.clock_i(clock_i), .rst_i(rst_i),
    .power_i(power_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
    .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .irq_n_o(irq_n_o), .frequency_pulse_o(frequency_pulse_o));
  eapo_pulse_counter eapo_pulse_counter_inst (.clock_i(clock_i), .rst_i(rst_i),
    .pulse_i(frequency_pulse_o), .count_o(count));
  initial
  begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("checked=%0d err_count=%0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_sim
  always @(posedge clock_i)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      err_count++;
      end_sim();
    end
  end
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Window compare for counts, where phase of the accumulators adds one either way.
  task automatic chk_rng(input int got, input int lo, input int hi);
    chk(40'(got), (got >= lo && got <= hi) ? 40'(got) : 40'(lo));
  endtask : chk_rng
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clock_i);
    reg_wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [39:0] d);
    @(posedge clock_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clock_i);
    reg_rd_i <= 1'b0;
    @(negedge clock_i);
    d = reg_rdata_o;
  endtask : rd
  task automatic wait_irq(output int n);
    n = 0;
    while (n < 1200)
    begin
      // The flag is looked at mid-cycle, once the launching edge has settled.
      @(negedge clock_i);
      n++;
      if (irq_n_o === 1'b0) break;
    end
  endtask : wait_irq
  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_reset_values();
    logic [39:0] d;
    rd(eapo_pkg::REG_DEN, d);
    chk(d, 40'h3f);
    rd(eapo_pkg::REG_NUM, d);
    chk(d, 40'h0);
    rd(eapo_pkg::REG_ENERGY, d);
    chk(d, 40'h0);
    rd(4'hf, d);
    chk(d, 40'h0);
    for (int a = 2; a < 10; a++)
    begin
      if (a != 3 && a != 4)
      begin
        rd(4'(a), d);
        chk(d, 40'h0);
      end
    end
  endtask : test_reset_values
  // Every 400 cycles hold exactly 100 updates, whatever the strobe phase.
  task automatic test_energy();
    int pw[5] = '{3000, -1000, 0, 4096, 0};
    logic [15:0] of[5] = '{16'h0000, 16'h0000, 16'h0100, 16'h0000, 16'hff00};
    logic [11:0] gn[5] = '{12'h000, 12'h000, 12'h000, 12'h7ff, 12'h000};
    int ex[5] = '{3000, -1000, 1, 6143, -1};
    logic [39:0] e1, e2;
    for (int i = 0; i < 5; i++)
    begin
      @(posedge clock_i);
      power_i <= PW'(pw[i]);
      wr(eapo_pkg::REG_OFFSET, of[i]);
      wr(eapo_pkg::REG_GAIN, {4'h0, gn[i]});
      rd(eapo_pkg::REG_OFFSET, e1);
      chk(e1, 40'(of[i]));
      rd(eapo_pkg::REG_ENERGY, e1);
      repeat (398) @(posedge clock_i);
      rd(eapo_pkg::REG_ENERGY_ALIAS, e2);
      chk(e2 - e1, 40'(100 * ex[i]));
    end
  endtask : test_energy
  // Power 2^18 gives one conversion pulse per 32 updates, that is 128 cycles.
  task automatic test_pulses();
    int nm[2] = '{0, 1};
    int dn[2] = '{0, 3};
    logic [15:0] c1;
    wr(eapo_pkg::REG_OFFSET, 16'h0000);
    wr(eapo_pkg::REG_GAIN, 16'h0000);
    @(posedge clock_i);
    power_i <= 20'h40000;
    for (int i = 0; i < 2; i++)
    begin
      // Denominator first, so it never falls below the numerator in between.
      wr(eapo_pkg::REG_DEN, 16'(dn[i]));
      wr(eapo_pkg::REG_NUM, 16'(nm[i]));
      repeat (300) @(posedge clock_i);
      c1 = count;
      repeat (2560) @(posedge clock_i);
      chk_rng(int'(count - c1), 20 * (nm[i] + 1) / (dn[i] + 1) - 1,
        20 * (nm[i] + 1) / (dn[i] + 1) + 1);
    end
  endtask : test_pulses
  // A status read clears two edges after detection, so the gap shrinks by two.
  task automatic test_samples();
    logic [39:0] d;
    int n;
    @(posedge clock_i);
    power_i <= 20'd5000;
    wr(eapo_pkg::REG_IRQ_EN, 16'h0008);
    for (int r = 0; r < 4; r++)
    begin
      wr(eapo_pkg::REG_MODE, 16'(r << 11));
      wait_irq(n);
      rd(eapo_pkg::REG_WAVEFORM, d);
      chk({20'h0, d[19:0]}, 40'd5000);
      rd(eapo_pkg::REG_IRQ_STATUS, d);
      wait_irq(n);
      rd(eapo_pkg::REG_IRQ_STATUS, d);
      chk({39'h0, irq_n_o}, 40'h1);
      wait_irq(n);
      chk_rng(n, (128 << r) - 3, (128 << r) - 1);
    end
    wr(eapo_pkg::REG_MODE, 16'h2000);
    rd(eapo_pkg::REG_IRQ_STATUS, d);
    repeat (300) @(posedge clock_i);
    @(negedge clock_i);
    chk({39'h0, irq_n_o}, 40'h1);
    wr(eapo_pkg::REG_IRQ_EN, 16'h0000);
    repeat (300) @(posedge clock_i);
    @(negedge clock_i);
    chk({39'h0, irq_n_o}, 40'h1);
  endtask : test_samples
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    rst_i = 1'b1;
    power_i = '0;
    reg_addr_i = '0;
    reg_wr_i = 1'b0;
    reg_wdata_i = '0;
    reg_rd_i = 1'b0;
    repeat (6) @(posedge clock_i);
    rst_i <= 1'b0;
    test_reset_values();
    test_energy();
    test_pulses();
    test_samples();
    end_sim();
  end
endmodule : eapo_energy_accumulator_pulse_out_bench
